/* hw/e1_rx_status_monitor.sv */
`timescale 1ns/100ps
module e1_rx_status_monitor #(parameter int JA_DEPTH = 32) (
	input wire logic clk,
	input wire logic rst_n,
	input e1_rx_status_pkg::reg_req_t regReq,
	output logic [7:0] rdData,
	output logic intN,
	input wire logic bitStb,
	input wire logic recoveredDataPosIn,
	input wire logic recoveredDataNegIn,
	input wire logic lineRxTip,
	input wire logic lineRxRing,
	input wire logic ts16Bit,
	input wire logic mfEnd,
	input wire logic dmaStb,
	input wire logic dmaBit,
	input wire logic nafStb,
	input wire logic nafBit3,
	input wire logic fasWordStb,
	input wire logic fasWordErr,
	input wire logic casWordStb,
	input wire logic casWordErr,
	input wire logic crcWordStb,
	input wire logic crcWordErr,
	input wire logic fasFalseLock,
	input wire logic crc4SearchTimeout,
	input wire logic crc4SyncGained,
	input wire logic crc4FramingEnable,
	input wire logic extendedCarrierLossSel,
	input wire logic framerAligned,
	input wire logic fasSearchActive,
	input wire logic casMfSearchActive,
	input wire logic crc4MfSearchActive,
	input wire logic txStoreFullEv,
	input wire logic txStoreEmptyEv,
	input wire logic rxStoreFullEv,
	input wire logic rxStoreEmptyEv,
	input wire logic [$clog2(JA_DEPTH+1)-1:0] jaFill,
	output logic fasRecheck
);
	localparam int FW = $clog2(JA_DEPTH + 1);
	initial begin
		if (JA_DEPTH <= e1_rx_status_pkg::JA_MARGIN) $error("jitter depth too small");
	end

	// register decode
	wire selAlarm = regReq.addr == e1_rx_status_pkg::ADDR_ALARM;
	wire selInfo = regReq.addr == e1_rx_status_pkg::ADDR_INFO;
	wire selMask = regReq.addr == e1_rx_status_pkg::ADDR_MASK;
	wire selSync = regReq.addr == e1_rx_status_pkg::ADDR_SYNC;
	wire rdAlarm = regReq.rd && selAlarm;
	wire rdInfo = regReq.rd && selInfo;

	logic [7:0] alarmMask_r;
	logic [7:0] alarmView;
	logic [7:0] alarmLatched;
	logic [7:0] infoView;
	logic [7:0] infoLatched;
	logic [7:0] syncStat;

	// carrier loss on the line inputs
	logic [11:0] zeroRun_r;
	logic [7:0] clWin_r;
	logic [5:0] clOnes_r;
	logic carrierLoss_r;
	wire lineZero = !lineRxTip && !lineRxRing;
	wire [11:0] clLimit = extendedCarrierLossSel ? e1_rx_status_pkg::CL_ZEROS_EXT
		: e1_rx_status_pkg::CL_ZEROS_STD;
	wire [11:0] zeroRunInc = zeroRun_r + 12'h001;
	wire clSet = bitStb && lineZero && (zeroRunInc >= clLimit);
	wire [5:0] clOnesNxt = (lineZero || clOnes_r == e1_rx_status_pkg::CL_ONES) ? clOnes_r : clOnes_r + 6'h01;
	wire clWinEnd = bitStb && clWin_r == e1_rx_status_pkg::CL_WIN - 8'h01;
	wire clClr = clWinEnd && clOnesNxt >= e1_rx_status_pkg::CL_ONES;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zeroRun_r <= '0;
			clWin_r <= '0;
			clOnes_r <= '0;
			carrierLoss_r <= 1'b0;
		end else if (bitStb) begin
			zeroRun_r <= !lineZero ? 12'h000 : (clSet ? zeroRun_r : zeroRunInc);
			clWin_r <= (clWinEnd || !carrierLoss_r) ? 8'h00 : clWin_r + 8'h01;
			clOnes_r <= (clWinEnd || !carrierLoss_r) ? 6'h00 : clOnesNxt;
			if (clSet) begin
				carrierLoss_r <= 1'b1;
			end else if (clClr) begin
				carrierLoss_r <= 1'b0;
			end
		end
	end

	// unframed all ones on the recovered data, fixed 512-bit windows
	logic [8:0] uaWin_r;
	logic [1:0] uaZeros_r;
	logic unframedOnes_r;
	wire dataZero = !recoveredDataPosIn && !recoveredDataNegIn;
	wire [1:0] uaZerosNxt = (dataZero && uaZeros_r != e1_rx_status_pkg::MIN_ZEROS) ? uaZeros_r + 2'h1 : uaZeros_r;
	wire uaEnd = bitStb && uaWin_r == e1_rx_status_pkg::UA_WIN_LAST;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			uaWin_r <= '0;
			uaZeros_r <= '0;
			unframedOnes_r <= 1'b0;
		end else if (bitStb) begin
			uaWin_r <= uaWin_r + 9'h001;
			uaZeros_r <= uaEnd ? 2'h0 : uaZerosNxt;
			if (uaEnd) begin
				unframedOnes_r <= uaZerosNxt < e1_rx_status_pkg::MIN_ZEROS;
			end
		end
	end

	// timeslot 16 over each multiframe; a rolling signature spots signaling changes
	logic [1:0] tsZeros_r;
	logic tsOne_r;
	logic [7:0] sig_r;
	logic [7:0] prevSig_r;
	logic sigValid_r;
	logic sigAllOnes_r;
	logic sigAllZeros_r;
	logic sigChange_r;
	wire tsBit = bitStb && ts16Bit;
	wire tsData = recoveredDataPosIn || recoveredDataNegIn;
	wire [1:0] tsZerosNxt = (tsBit && !tsData && tsZeros_r != e1_rx_status_pkg::MIN_ZEROS) ? tsZeros_r + 2'h1
		: tsZeros_r;
	wire tsOneNxt = tsOne_r || (tsBit && tsData);
	wire [7:0] sigNxt = tsBit ? {sig_r[6:0], sig_r[7] ^ tsData} : sig_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tsZeros_r <= '0;
			tsOne_r <= 1'b0;
			sig_r <= '0;
			prevSig_r <= '0;
			sigValid_r <= 1'b0;
			sigAllOnes_r <= 1'b0;
			sigAllZeros_r <= 1'b0;
			sigChange_r <= 1'b0;
		end else begin
			sigChange_r <= mfEnd && sigValid_r && (sigNxt != prevSig_r);
			if (mfEnd) begin
				sigAllOnes_r <= tsZerosNxt < e1_rx_status_pkg::MIN_ZEROS;
				sigAllZeros_r <= !tsOneNxt;
				prevSig_r <= sigNxt;
				sigValid_r <= 1'b1;
				tsZeros_r <= '0;
				tsOne_r <= 1'b0;
				sig_r <= '0;
			end else begin
				tsZeros_r <= tsZerosNxt;
				tsOne_r <= tsOneNxt;
				sig_r <= sigNxt;
			end
		end
	end

	// consecutive-occurrence filters
	logic distantMf;
	logic farEnd;
	logic fasErrState;
	logic casErrState;
	logic fasRun;
	logic casRun;
	consec_filter #(.N(e1_rx_status_pkg::DMA_RUN)) uDma (.clk(clk), .rst_n(rst_n),
		.stb(dmaStb), .sample(dmaBit), .state(distantMf), .rise());
	consec_filter #(.N(e1_rx_status_pkg::RRA_RUN)) uRra (.clk(clk), .rst_n(rst_n),
		.stb(nafStb), .sample(nafBit3), .state(farEnd), .rise());
	consec_filter #(.N(e1_rx_status_pkg::FAS_ERR_RUN)) uFas (.clk(clk), .rst_n(rst_n),
		.stb(fasWordStb), .sample(fasWordErr), .state(fasErrState), .rise(fasRun));
	consec_filter #(.N(e1_rx_status_pkg::CAS_ERR_RUN)) uCas (.clk(clk), .rst_n(rst_n),
		.stb(casWordStb), .sample(casWordErr), .state(casErrState), .rise(casRun));

	// crc4 codeword error density over blocks of 1000
	logic [9:0] crcCnt_r;
	logic [9:0] crcErr_r;
	logic crcTrip_r;
	wire [9:0] crcErrNxt = crcErr_r + {9'h000, crcWordErr};
	wire crcEnd = crcWordStb && crcCnt_r == e1_rx_status_pkg::CRC_BLOCK - 10'h001;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crcCnt_r <= '0;
			crcErr_r <= '0;
			crcTrip_r <= 1'b0;
		end else begin
			crcTrip_r <= crcEnd && crcErrNxt >= e1_rx_status_pkg::CRC_ERR_TRIP;
			if (crcWordStb) begin
				crcCnt_r <= crcEnd ? 10'h000 : crcCnt_r + 10'h001;
				crcErr_r <= crcEnd ? 10'h000 : crcErrNxt;
			end
		end
	end

	// crc4 search counter and live synchronizer state
	logic [5:0] searchCnt_r;
	logic rxLos_r;
	logic jaTrip_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			searchCnt_r <= '0;
			rxLos_r <= 1'b0;
			jaTrip_r <= 1'b0;
			fasRecheck <= 1'b0;
			syncStat <= '0;
		end else begin
			if (!crc4FramingEnable || crc4SyncGained) begin
				searchCnt_r <= '0;
			end else if (crc4SearchTimeout) begin
				searchCnt_r <= searchCnt_r + 6'h01;
			end
			rxLos_r <= !framerAligned;
			jaTrip_r <= jaFill >= FW'(JA_DEPTH - e1_rx_status_pkg::JA_MARGIN);
			fasRecheck <= crc4MfSearchActive;
			syncStat <= {searchCnt_r[5:2], searchCnt_r[0], fasSearchActive,
				casMfSearchActive, crc4MfSearchActive};
		end
	end

	// latched registers
	wire [7:0] infoEv = {txStoreFullEv, txStoreEmptyEv, 1'b0, rxStoreFullEv, rxStoreEmptyEv,
		crcTrip_r, fasRun || (fasRecheck && fasFalseLock), casRun};
	wire [7:0] infoHold = {2'b00, jaTrip_r, 5'b00000};
	wire rxSlip = rxStoreFullEv || rxStoreEmptyEv;
	wire [7:0] alarmLvl = {sigAllOnes_r, distantMf, sigAllZeros_r, 1'b0, unframedOnes_r,
		farEnd, carrierLoss_r, rxLos_r};
	wire [7:0] alarmEv = {sigChange_r, 2'b00, rxSlip, 4'h0} | {sigChange_r, 2'b00, 5'h00}
		| {2'b00, sigChange_r, 5'h00};
	latch_reg #(.W(8)) uInfo (.clk(clk), .rst_n(rst_n), .setEv(infoEv), .hold(infoHold),
		.wrStb(regReq.wr && selInfo), .wrMask(regReq.wdata), .rdStb(rdInfo),
		.view(infoView), .latched(infoLatched));
	latch_reg #(.W(8)) uAlarm (.clk(clk), .rst_n(rst_n), .setEv(alarmEv), .hold(alarmLvl),
		.wrStb(regReq.wr && selAlarm), .wrMask(regReq.wdata), .rdStb(rdAlarm),
		.view(alarmView), .latched(alarmLatched));

	// interrupt: low-order alarms interrupt on either edge, bits 7 and 5 on onset or signaling change, bit 4 on slip
	logic [7:0] alarmPrev_r;
	logic [7:0] pend_r;
	logic [7:0] alarmSel_r;
	wire [7:0] lvlEdge = alarmLvl ^ alarmPrev_r;
	wire [7:0] intCause = alarmEv | (lvlEdge & {alarmLvl[7:5], 1'b0, 4'hf});
	// only bits the host selected for this read release the pin
	wire [7:0] pendClr = rdAlarm ? (alarmView & alarmSel_r) : 8'h00;
	wire [7:0] pend_nxt = (pend_r & ~pendClr) | (intCause & alarmMask_r);
	wire [7:0] rdMux = selAlarm ? alarmView : selInfo ? infoView : selMask ? alarmMask_r
		: selSync ? syncStat : 8'h00;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alarmPrev_r <= '0;
			pend_r <= '0;
			alarmMask_r <= e1_rx_status_pkg::MASK_RESET;
			alarmSel_r <= '0;
			intN <= 1'b1;
			rdData <= '0;
		end else begin
			alarmPrev_r <= alarmLvl;
			pend_r <= pend_nxt;
			intN <= !(|(pend_nxt & alarmMask_r));
			if (regReq.wr && selAlarm) begin
				alarmSel_r <= regReq.wdata;
			end
			if (regReq.wr && selMask) begin
				alarmMask_r <= regReq.wdata;
			end
			if (regReq.rd) begin
				rdData <= rdMux;
			end
		end
	end

	property p_txFull;
		@(posedge clk) disable iff (!rst_n) txStoreFullEv |=> infoLatched[e1_rx_status_pkg::I_TXF];
	endproperty
	a_txFull: assert property (p_txFull) else $error("tx store full not latched");
	property p_slip;
		@(posedge clk) disable iff (!rst_n) rxStoreEmptyEv |=> alarmLatched[e1_rx_status_pkg::A_SLIP]
			&& infoLatched[e1_rx_status_pkg::I_RXE];
	endproperty
	a_slip: assert property (p_slip) else $error("rx slip not latched");
	property p_ja;
		@(posedge clk) disable iff (!rst_n) jaFill >= FW'(JA_DEPTH - e1_rx_status_pkg::JA_MARGIN)
			|=> ##1 infoLatched[e1_rx_status_pkg::I_JA];
	endproperty
	a_ja: assert property (p_ja) else $error("jitter trip missed");
	property p_cntInc;
		@(posedge clk) disable iff (!rst_n) crc4SearchTimeout && crc4FramingEnable && !crc4SyncGained
			|=> searchCnt_r == $past(searchCnt_r) + 6'h01;
	endproperty
	a_cntInc: assert property (p_cntInc) else $error("search count did not step");
	property p_cntClr;
		@(posedge clk) disable iff (!rst_n) !crc4FramingEnable |=> searchCnt_r == 6'h00;
	endproperty
	a_cntClr: assert property (p_cntClr) else $error("search count not cleared");
	property p_los;
		@(posedge clk) disable iff (!rst_n) !framerAligned |=> ##1 alarmLatched[e1_rx_status_pkg::A_LOS];
	endproperty
	a_los: assert property (p_los) else $error("loss of sync not flagged");
	property p_ssr;
		@(posedge clk) disable iff (!rst_n) regReq.rd && selSync |=> rdData == $past(syncStat)
			&& ($stable(alarmLatched) || $past(|alarmEv) || $past(|alarmLvl));
	endproperty
	a_ssr: assert property (p_ssr) else $error("sync status read wrong");
	property p_int;
		@(posedge clk) disable iff (!rst_n) |(intCause & alarmMask_r) |=> !intN ##0 pend_r != 8'h00;
	endproperty
	a_int: assert property (p_int) else $error("interrupt not asserted");
	property p_mask;
		@(posedge clk) disable iff (!rst_n) alarmMask_r == 8'h00 |=> intN;
	endproperty
	a_mask: assert property (p_mask) else $error("masked interrupt fired");
endmodule

/* pkg/e1_rx_status_pkg.sv */
package e1_rx_status_pkg;
	localparam logic [7:0] ADDR_ALARM = 8'h06;
	localparam logic [7:0] ADDR_INFO = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h16;
	localparam logic [7:0] ADDR_SYNC = 8'h1e;
	localparam logic [7:0] MASK_RESET = 8'h00;
	// alarm register bit positions
	localparam int A_SA1 = 7;
	localparam int A_DMA = 6;
	localparam int A_SA0 = 5;
	localparam int A_SLIP = 4;
	localparam int A_UA1 = 3;
	localparam int A_RRA = 2;
	localparam int A_RCL = 1;
	localparam int A_LOS = 0;
	// information register bit positions
	localparam int I_TXF = 7;
	localparam int I_TXE = 6;
	localparam int I_JA = 5;
	localparam int I_RXF = 4;
	localparam int I_RXE = 3;
	localparam int I_CRC = 2;
	localparam int I_FAS = 1;
	localparam int I_CAS = 0;
	localparam int FAS_ERR_RUN = 3;
	localparam int CAS_ERR_RUN = 2;
	localparam int DMA_RUN = 2;
	localparam int RRA_RUN = 3;
	localparam logic [9:0] CRC_BLOCK = 10'h3e8;
	localparam logic [9:0] CRC_ERR_TRIP = 10'h393;
	localparam logic [11:0] CL_ZEROS_STD = 12'h0ff;
	localparam logic [11:0] CL_ZEROS_EXT = 12'h800;
	localparam logic [7:0] CL_WIN = 8'hff;
	localparam logic [5:0] CL_ONES = 6'h20;
	localparam logic [8:0] UA_WIN_LAST = 9'h1ff;
	localparam logic [1:0] MIN_ZEROS = 2'h3;
	localparam int JA_MARGIN = 4;
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

/* hw/consec_filter.sv */
`timescale 1ns/100ps
// state flips after N consecutive strobed samples disagreeing with it
module consec_filter #(parameter int N = 3) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic stb,
	input wire logic sample,
	output logic state,
	output logic rise
);
	localparam int CW = $clog2(N + 1);
	logic [CW-1:0] run_r;
	wire differ = stb && (sample != state);
	wire flip = differ && (run_r == CW'(N - 1));
	initial begin
		if (N < 1) $error("consec_filter needs N of at least one");
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= '0;
			state <= 1'b0;
			rise <= 1'b0;
		end else begin
			rise <= flip && !state;
			if (flip) begin
				run_r <= '0;
				state <= ~state;
			end else if (differ) begin
				run_r <= run_r + 1'b1;
			end else if (stb) begin
				run_r <= '0;
			end
		end
	end
endmodule

/* hw/latch_reg.sv */
`timescale 1ns/100ps
// sticky flags with a host-selected read view; set and persisting level beat the read clear
module latch_reg #(parameter int W = 8) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] setEv,
	input wire logic [W-1:0] hold,
	input wire logic wrStb,
	input wire logic [W-1:0] wrMask,
	input wire logic rdStb,
	output logic [W-1:0] view,
	output logic [W-1:0] latched
);
	// a read clears only what the last mask write asked for; stale view bits keep their flags
	logic [W-1:0] sel_r;
	wire [W-1:0] rdClr = rdStb ? (view & sel_r) : '0;
	wire [W-1:0] latch_nxt = (latched & ~rdClr) | setEv | hold;
	wire [W-1:0] view_nxt = wrStb ? ((wrMask & latched) | (~wrMask & view)) : view;
	initial begin
		if (W < 1) $error("latch_reg needs a width");
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latched <= '0;
			view <= '0;
			sel_r <= '0;
		end else begin
			latched <= latch_nxt;
			view <= view_nxt;
			sel_r <= wrStb ? wrMask : sel_r;
		end
	end
endmodule

/* verif/e1_host_model.sv */
`timescale 1ns/100ps
module e1_host_model (
	input wire logic clk,
	input wire logic [7:0] rdData,
	output e1_rx_status_pkg::reg_req_t regReq
);
	initial begin
		regReq = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
	end
	// idle bus shows inverted leftovers so a stale address or data byte never looks live
	task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		regReq = '{addr: a, wr: w, rd: !w, wdata: d};
		@(negedge clk);
		regReq = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
		q = rdData;
		// one idle edge, so a strobe is never lowered and raised in the same step
		@(negedge clk);
	endtask
	task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] q);
		logic [7:0] junk;
		access(a, 1'b1, m, junk);
		access(a, 1'b0, 8'h00, q);
		access(a, 1'b1, q & m, junk);
	endtask
	// search counter steps are 8 ms apart; from 400 ms on the host gives up on crc4 sync
	function automatic logic overdue(input int timeouts);
		return timeouts * 8 >= 400;
	endfunction
endmodule

/* verif/e1_receive_alarm_status_monitor_tb.sv */
`timescale 1ns/100ps
module e1_receive_alarm_status_monitor_tb;
	logic clk, rst_n, intN, fasRecheck;
	e1_rx_status_pkg::reg_req_t regReq;
	logic [7:0] rdData, q;
	logic bitStb, posIn, negIn, tip, ring, ts16, mfEnd, dmaStb, dmaBit, nafStb, nafBit;
	logic fasStb, fasErr, casStb, casErr, crcStb, crcErr, falseLock, tmo, gained, crcEn, extSel, aligned;
	logic fas_search_active, cas_mf_search_active, crcSa, txF, txE, rxF, rxE;
	logic [5:0] jaFill, cnt;
	logic [31:0] seed, r;
	logic [127:0] pat;
	int fails, check_count, n, tot;
	e1_rx_status_monitor u_dut (.clk(clk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData), .intN(intN),
		.bitStb(bitStb), .recoveredDataPosIn(posIn), .recoveredDataNegIn(negIn), .lineRxTip(tip),
		.lineRxRing(ring), .ts16Bit(ts16), .mfEnd(mfEnd), .dmaStb(dmaStb), .dmaBit(dmaBit), .nafStb(nafStb),
		.nafBit3(nafBit), .fasWordStb(fasStb), .fasWordErr(fasErr), .casWordStb(casStb), .casWordErr(casErr),
		.crcWordStb(crcStb), .crcWordErr(crcErr), .fasFalseLock(falseLock), .crc4SearchTimeout(tmo),
		.crc4SyncGained(gained), .crc4FramingEnable(crcEn), .extendedCarrierLossSel(extSel),
		.framerAligned(aligned), .fasSearchActive(fas_search_active), .casMfSearchActive(cas_mf_search_active),
		.crc4MfSearchActive(crcSa), .txStoreFullEv(txF), .txStoreEmptyEv(txE), .rxStoreFullEv(rxF),
		.rxStoreEmptyEv(rxE), .jaFill(jaFill), .fasRecheck(fasRecheck));
	e1_host_model u_host (.clk(clk), .rdData(rdData), .regReq(regReq));
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	function automatic logic [7:0] syncExp(input logic [5:0] c, input logic [2:0] sa);
		return {c[5:2], c[0], sa};
	endfunction
	task automatic rnd();
		seed = xorshift(seed);
		r = seed;
	endtask
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results();
		if (fails == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic checkInt(input logic e);
		check("intN", {7'h00, e}, {7'h00, intN});
	endtask
	task automatic flags(input logic info, input logic [7:0] m, input logic [7:0] e);
		repeat (3) @(negedge clk);
		u_host.poll(info ? e1_rx_status_pkg::ADDR_INFO : e1_rx_status_pkg::ADDR_ALARM, m, q);
		check("flags", e & m, q & m);
	endtask
	// a read only clears a latched alarm once it has gone, so one poll empties it first
	task automatic flush(input logic [7:0] m);
		u_host.poll(e1_rx_status_pkg::ADDR_ALARM, m, q);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask
	task automatic strobe(ref logic stb, ref logic b, input logic v, input int k);
		repeat (k) begin
			b = v;
			pulse(stb);
		end
	endtask
	task automatic words(ref logic stb, ref logic err, input int k, input int bad);
		for (int i = 0; i < k; i++) begin
			stb = 1'b1;
			err = i < bad;
			@(negedge clk);
		end
		stb = 1'b0;
		err = 1'b0;
	endtask
	task automatic persist(ref logic stb, ref logic b, input int need, input logic [7:0] m);
		strobe(stb, b, 1'b1, need - 1);
		flags(0, m, 8'h00);
		strobe(stb, b, 1'b1, 1);
		flags(0, m, m);
		strobe(stb, b, 1'b0, need);
		flush(m);
		flags(0, m, 8'h00);
	endtask
	task automatic line(input int k, input logic v, input int gap);
		for (int i = 0; i < k; i++) begin
			posIn = (gap > 0) ? (i % gap != 0) : v;
			tip = posIn;
			bitStb = 1'b1;
			@(negedge clk);
		end
		bitStb = 1'b0;
	endtask
	task automatic mf(input logic [127:0] p);
		ts16 = 1'b1;
		for (int i = 0; i < 128; i++) begin
			{bitStb, posIn, tip, mfEnd} = {1'b1, p[i], p[i], i == 127};
			@(negedge clk);
		end
		{bitStb, ts16, mfEnd} = 3'h0;
		@(negedge clk);
	endtask
	task automatic syncCheck();
		logic [7:0] e;
		e = syncExp(cnt, {fas_search_active, cas_mf_search_active, crcSa});
		repeat (2) @(negedge clk);
		u_host.access(e1_rx_status_pkg::ADDR_SYNC, 1'b0, 8'h00, q);
		check("sync", e, q);
		u_host.access(e1_rx_status_pkg::ADDR_SYNC, 1'b0, 8'h00, q);
		check("sync reread", e, q);
		check("recheck", {7'h00, crcSa}, {7'h00, fasRecheck});
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#4000000;
		fails++;
		results();
	end
	initial begin
		{rst_n, bitStb, posIn, negIn, tip, ring, ts16, mfEnd, dmaStb, dmaBit, nafStb, nafBit} = '0;
		{fasStb, fasErr, casStb, casErr, crcStb, crcErr, falseLock, tmo, gained, crcEn, extSel} = '0;
		{fas_search_active, cas_mf_search_active, crcSa, txF, txE, rxF, rxE, jaFill, cnt} = '0;
		aligned = 1'b1;
		seed = 32'h0000001e;
		fails = 0;
		tot = 0;
		check_count = 0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		checkInt(1'b1);
		u_host.access(e1_rx_status_pkg::ADDR_MASK, 1'b0, 8'h00, q);
		check("mask", e1_rx_status_pkg::MASK_RESET, q);
		u_host.access(8'h40, 1'b0, 8'h00, q);
		check("unmapped", 8'h00, q);
		flags(0, 8'hff, 8'h00);
		flags(1, 8'hff, 8'h00);
		pulse(rxF);
		checkInt(1'b1);
		flags(1, 8'h10, 8'h10);
		flags(0, 8'h10, 8'h10);
		u_host.access(e1_rx_status_pkg::ADDR_MASK, 1'b1, 8'h10, q);
		pulse(rxE);
		checkInt(1'b0);
		flags(1, 8'h08, 8'h08);
		checkInt(1'b0);
		flags(0, 8'h10, 8'h10);
		checkInt(1'b1);
		pulse(txF);
		pulse(txE);
		flags(1, 8'hc0, 8'hc0);
		flags(1, 8'hc0, 8'h00);
		jaFill = 6'h1b;
		flags(1, 8'h20, 8'h00);
		jaFill = 6'h1c;
		flags(1, 8'h20, 8'h20);
		jaFill = 6'h00;
		words(fasStb, fasErr, 3, 2);
		flags(1, 8'h02, 8'h00);
		words(fasStb, fasErr, 3, 3);
		flags(1, 8'h02, 8'h02);
		pulse(falseLock);
		flags(1, 8'h02, 8'h00);
		crcSa = 1'b1;
		@(negedge clk);
		pulse(falseLock);
		crcSa = 1'b0;
		flags(1, 8'h02, 8'h02);
		words(casStb, casErr, 2, 1);
		flags(1, 8'h01, 8'h00);
		words(casStb, casErr, 2, 2);
		flags(1, 8'h01, 8'h01);
		words(crcStb, crcErr, 1000, 914);
		flags(1, 8'h04, 8'h00);
		words(crcStb, crcErr, 1000, 915);
		flags(1, 8'h04, 8'h04);
		crcEn = 1'b1;
		for (int k = 0; k < 3; k++) begin
			rnd();
			n = (k == 2) ? 64 + int'(r[5:0]) : int'(r[5:0]);
			repeat (n) pulse(tmo);
			tot += n;
			{fas_search_active, cas_mf_search_active, crcSa} = r[10:8];
			cnt = cnt + r[5:0];
			syncCheck();
		end
		pulse(gained);
		cnt = 6'h00;
		syncCheck();
		repeat (5) pulse(tmo);
		tot += 5;
		crcEn = !u_host.overdue(tot);
		syncCheck();
		mf({128{1'b1}});
		flags(0, 8'h80, 8'h80);
		mf(128'h0);
		flags(0, 8'h20, 8'h20);
		for (int i = 0; i < 4; i++) begin
			rnd();
			pat[32*i +: 32] = r;
		end
		pat[3:0] = 4'h8;
		mf(pat);
		mf(pat);
		flush(8'ha0);
		flags(0, 8'ha0, 8'h00);
		mf(pat ^ (128'h1 << 64));
		flags(0, 8'ha0, 8'ha0);
		persist(dmaStb, dmaBit, 2, 8'h40);
		persist(nafStb, nafBit, 3, 8'h04);
		// fixed windows have unknown phase, so twice the span guarantees one whole window
		line(1024, 1'b1, 100);
		flush(8'h08);
		flags(0, 8'h08, 8'h00);
		line(1024, 1'b1, 0);
		flags(0, 8'h08, 8'h08);
		extSel = 1'b1;
		line(2047, 1'b0, 0);
		flags(0, 8'h02, 8'h00);
		line(1, 1'b0, 0);
		flags(0, 8'h02, 8'h02);
		line(300, 1'b1, 0);
		extSel = 1'b0;
		flush(8'h02);
		flags(0, 8'h02, 8'h00);
		line(254, 1'b0, 0);
		flags(0, 8'h02, 8'h00);
		line(1, 1'b0, 0);
		flags(0, 8'h02, 8'h02);
		aligned = 1'b0;
		flags(0, 8'h01, 8'h01);
		flags(0, 8'h01, 8'h01);
		aligned = 1'b1;
		flush(8'h01);
		flags(0, 8'h01, 8'h00);
		results();
	end
endmodule
